// File: rtl/csd_clock_supervision.sv
// Overview of operation
// - an oscillator leaving its frequency window sets the failure flag and moves the clock to the internal low-power oscillator.
// - the failure flag and limp switchover hold until a power-on reset, even if the oscillator recovers.
// - the external clock output runs at the peripheral bus clock divided by N = prescale field [15:0] plus one.
// - the peripheral bus clock ratio X = 1..16 comes from bits [19:16] of the clock divider control register.
// - a read-only 64-bit die identifier is readable as a low and a high word.
// - the first two PLL control registers drive the modulated primary PLL, the third drives the secondary PLL.
// - after reset the PLL control registers hold 0x2F025F00, 0x7FC07200 and 0x00000307.
// - a read-only identification register shows device attributes including the silicon revision.
`timescale 1ns/100ps
`default_nettype none
module csd_clock_supervision #(
    parameter logic [31:0] DIE_ID_LOW = 32'h00000000,   // arbitrary, per-unit value
    parameter logic [31:0] DIE_ID_HIGH = 32'h00000000,  // arbitrary, per-unit value
    parameter logic [31:0] DEVICE_IDENTITY = 32'h00000001     // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic por_rst,
    input wire logic oscillator_input_pin,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic osc_clock_enable,
    output logic lpo_clock_enable,
    output logic osc_failure_flag,
    output logic peripheral_bus_clock_en,
    output logic external_clock_output,
    output logic [31:0] pll_control_one,
    output logic [31:0] pll_control_two,
    output logic [31:0] pll_control_three,
    output logic irq
);
    function automatic logic [31:0] csd_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic any_rst;
    assign any_rst = rst || por_rst;

    // oscillator sampling and window measurement
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [csd_pkg::WIN_W-1:0] win_cnt;
    logic [csd_pkg::WIN_W-1:0] edge_cnt;
    logic win_end;
    logic win_bad;

    always_ff @(posedge clk) begin
        osc_s1 <= oscillator_input_pin;
        osc_s2 <= osc_s1;
        osc_s3 <= osc_s2;
    end

    assign win_end = (win_cnt == csd_pkg::WIN_LAST);
    assign win_bad = (edge_cnt < csd_pkg::OSC_EDGES_MIN) || (edge_cnt > csd_pkg::OSC_EDGES_MAX);

    always_ff @(posedge clk) begin
        if (any_rst || win_end) begin
            win_cnt <= '0;
        end else begin
            win_cnt <= win_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst || win_end) begin
            edge_cnt <= '0;
        end else if (osc_s2 && !osc_s3 && edge_cnt != csd_pkg::EDGE_SAT) begin
            edge_cnt <= edge_cnt + 8'h01;
        end
    end

    // supervisor: only power-on reset leaves limp
    csd_pkg::csd_sup_state_t sup_state;
    logic [csd_pkg::GAP_W-1:0] gap_cnt;
    logic fail_event;

    assign fail_event = (sup_state == csd_pkg::CSD_SUP_OSC) && win_end && win_bad;

    always_ff @(posedge clk) begin
        if (por_rst) begin
            sup_state <= csd_pkg::CSD_SUP_OSC;
        end else begin
            unique case (sup_state)
                csd_pkg::CSD_SUP_OSC: begin
                    if (fail_event) begin
                        sup_state <= csd_pkg::CSD_SUP_GAP;
                    end
                end
                csd_pkg::CSD_SUP_GAP: begin
                    if (gap_cnt == csd_pkg::GAP_LAST) begin
                        sup_state <= csd_pkg::CSD_SUP_LIMP;
                    end
                end
                csd_pkg::CSD_SUP_LIMP: begin
                    sup_state <= csd_pkg::CSD_SUP_LIMP;
                end
                default: begin
                    sup_state <= csd_pkg::CSD_SUP_LIMP;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (por_rst || sup_state != csd_pkg::CSD_SUP_GAP) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 3'h1;
        end
    end

    // flag ignores warm reset so software can see why it limps
    always_ff @(posedge clk) begin
        if (por_rst) begin
            osc_failure_flag <= 1'b0;
        end else if (fail_event) begin
            osc_failure_flag <= 1'b1;
        end
    end

    // break before make: the gap lets the old clock finish its pulse
    assign osc_clock_enable = (sup_state == csd_pkg::CSD_SUP_OSC);
    assign lpo_clock_enable = (sup_state == csd_pkg::CSD_SUP_LIMP);

    // registers
    logic [31:0] ext_clock_prescale_ctl;
    logic [31:0] clock_divider_ctl;
    logic [csd_pkg::EVT_W-1:0] irq_status;
    logic [csd_pkg::EVT_W-1:0] irq_mask;

    // axi write path: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_hit;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        unique case (aw_addr)
            csd_pkg::ADDR_PLL_CONTROL_ONE, csd_pkg::ADDR_PLL_CONTROL_TWO, csd_pkg::ADDR_PLL_CONTROL_THREE,
            csd_pkg::ADDR_DIE_IDENTITY_LOW, csd_pkg::ADDR_DIE_IDENTITY_HIGH, csd_pkg::ADDR_DEVICE_IDENTITY,
            csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL, csd_pkg::ADDR_CLOCK_DIVIDER_CTL,
            csd_pkg::ADDR_SUPERVISOR_STATE, csd_pkg::ADDR_IRQ_STATUS, csd_pkg::ADDR_IRQ_MASK: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            aw_held <= 1'b0;
            aw_addr <= csd_pkg::RST_ZERO;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            w_held <= 1'b0;
            w_data <= csd_pkg::RST_ZERO;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csd_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            pll_control_one <= csd_pkg::RST_PLL_CONTROL_ONE;
            pll_control_two <= csd_pkg::RST_PLL_CONTROL_TWO;
            pll_control_three <= csd_pkg::RST_PLL_CONTROL_THREE;
            ext_clock_prescale_ctl <= csd_pkg::RST_ZERO;
            clock_divider_ctl <= csd_pkg::RST_ZERO;
            irq_mask <= '0;
        end else if (do_write) begin
            unique case (aw_addr)
                csd_pkg::ADDR_PLL_CONTROL_ONE: begin
                    pll_control_one <= csd_merge(pll_control_one, w_data, w_strb);
                end
                csd_pkg::ADDR_PLL_CONTROL_TWO: begin
                    pll_control_two <= csd_merge(pll_control_two, w_data, w_strb);
                end
                csd_pkg::ADDR_PLL_CONTROL_THREE: begin
                    pll_control_three <= csd_merge(pll_control_three, w_data, w_strb);
                end
                csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL: begin
                    ext_clock_prescale_ctl <= csd_merge(ext_clock_prescale_ctl, w_data, w_strb);
                end
                csd_pkg::ADDR_CLOCK_DIVIDER_CTL: begin
                    clock_divider_ctl <= csd_merge(clock_divider_ctl, w_data, w_strb);
                end
                csd_pkg::ADDR_IRQ_MASK: begin
                    if (w_strb[0]) begin
                        irq_mask <= w_data[csd_pkg::EVT_W-1:0];
                    end
                end
                default: begin
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // axi read path
    logic [31:0] rd_word;
    logic rd_hit;
    logic rd_fire;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

    always_comb begin
        rd_word = csd_pkg::RST_ZERO;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            csd_pkg::ADDR_PLL_CONTROL_ONE: rd_word = pll_control_one;
            csd_pkg::ADDR_PLL_CONTROL_TWO: rd_word = pll_control_two;
            csd_pkg::ADDR_PLL_CONTROL_THREE: rd_word = pll_control_three;
            csd_pkg::ADDR_DIE_IDENTITY_LOW: rd_word = DIE_ID_LOW;
            csd_pkg::ADDR_DIE_IDENTITY_HIGH: rd_word = DIE_ID_HIGH;
            csd_pkg::ADDR_DEVICE_IDENTITY: rd_word = DEVICE_IDENTITY;
            csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL: rd_word = ext_clock_prescale_ctl;
            csd_pkg::ADDR_CLOCK_DIVIDER_CTL: rd_word = clock_divider_ctl;
            csd_pkg::ADDR_SUPERVISOR_STATE: begin
                rd_word[csd_pkg::SUP_FAIL_BIT] = osc_failure_flag;
                rd_word[csd_pkg::SUP_LIMP_BIT] = lpo_clock_enable;
            end
            csd_pkg::ADDR_IRQ_STATUS: rd_word[csd_pkg::EVT_W-1:0] = irq_status;
            csd_pkg::ADDR_IRQ_MASK: rd_word[csd_pkg::EVT_W-1:0] = irq_mask;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= csd_pkg::RST_ZERO;
            s_axi_rresp <= csd_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // read clears status; a failure in the same cycle wins
    always_ff @(posedge clk) begin
        if (any_rst) begin
            irq_status <= '0;
        end else if (fail_event) begin
            irq_status[csd_pkg::EVT_OSC_FAIL_BIT] <= 1'b1;
        end else if (rd_fire && s_axi_araddr == csd_pkg::ADDR_IRQ_STATUS) begin
            irq_status <= '0;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // clock dividers
    csd_div_if #(.W(csd_pkg::BUS_DIV_W)) bus_div ();
    csd_div_if #(.W(csd_pkg::PRESCALE_W)) ecp_div ();

    assign bus_div.ratio = clock_divider_ctl[csd_pkg::BUS_DIV_LSB +: csd_pkg::BUS_DIV_W];
    assign bus_div.tick_in = 1'b1;
    assign ecp_div.ratio = ext_clock_prescale_ctl[csd_pkg::PRESCALE_LSB +: csd_pkg::PRESCALE_W];
    assign ecp_div.tick_in = bus_div.tick_out;
    assign peripheral_bus_clock_en = bus_div.tick_out;
    assign external_clock_output = ecp_div.level;

    csd_divider #(.W(csd_pkg::BUS_DIV_W)) u_bus_div (
        .clk(clk),
        .rst(any_rst),
        .d(bus_div.div)
    );

    csd_divider #(.W(csd_pkg::PRESCALE_W)) u_ecp_div (
        .clk(clk),
        .rst(any_rst),
        .d(ecp_div.div)
    );

    // checks
    sequence s_window_fail;
        (sup_state == csd_pkg::CSD_SUP_OSC) && win_end && win_bad;
    endsequence

    sequence s_limp_entry;
        osc_failure_flag && !osc_clock_enable ##[1:6] lpo_clock_enable;
    endsequence

    property p_limp_entry;
        @(posedge clk) disable iff (por_rst) s_window_fail |=> s_limp_entry;
    endproperty

    a_limp_entry: assert property (p_limp_entry) else $error("limp not entered after window failure");

    a_fail_sticky: assert property (@(posedge clk) disable iff (por_rst)
        (osc_failure_flag || lpo_clock_enable) |=> (osc_failure_flag && !osc_clock_enable))
        else $error("failure state left without power-on reset");

    a_switch_gap: assert property (@(posedge clk) disable iff (por_rst)
        $fell(osc_clock_enable) |-> (!lpo_clock_enable && !osc_clock_enable) [*3])
        else $error("clock enables overlap during switchover");

    a_bus_div_one: assert property (@(posedge clk) disable iff (any_rst)
        ($past(bus_div.ratio) == 4'h0 && !$past(any_rst)) |-> peripheral_bus_clock_en)
        else $error("peripheral bus enable missing with ratio one");

    a_external_clock_output_div_two: assert property (@(posedge clk) disable iff (any_rst)
        (bus_div.tick_out && ecp_div.ratio == 16'h0001 && $stable(ecp_div.ratio))
        |=> external_clock_output != $past(external_clock_output))
        else $error("external clock not toggling with prescale two");

    a_die_id_read: assert property (@(posedge clk) disable iff (any_rst)
        (rd_fire && s_axi_araddr == csd_pkg::ADDR_DIE_IDENTITY_HIGH)
        |=> (s_axi_rvalid && s_axi_rdata == DIE_ID_HIGH && s_axi_rresp == csd_pkg::RESP_OKAY))
        else $error("die identity high word wrong");

    a_device_identity_read: assert property (@(posedge clk) disable iff (any_rst)
        (rd_fire && s_axi_araddr == csd_pkg::ADDR_DEVICE_IDENTITY) |=> (s_axi_rdata == DEVICE_IDENTITY))
        else $error("device identity word wrong");

    a_pll_defaults: assert property (@(posedge clk)
        $past(any_rst) |-> (pll_control_one == csd_pkg::RST_PLL_CONTROL_ONE
        && pll_control_two == csd_pkg::RST_PLL_CONTROL_TWO && pll_control_three == csd_pkg::RST_PLL_CONTROL_THREE))
        else $error("pll control defaults wrong after reset");

    a_pll_three_write: assert property (@(posedge clk) disable iff (any_rst)
        (do_write && aw_addr == csd_pkg::ADDR_PLL_CONTROL_THREE && w_strb == 4'hF)
        |=> (pll_control_three == $past(w_data) && $stable(pll_control_one) && $stable(pll_control_two)))
        else $error("pll control three write misrouted");
endmodule
`default_nettype wire

// File: rtl/csd_div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface csd_div_if #(parameter int W = 4);
    logic [W-1:0] ratio;
    logic tick_in;
    logic tick_out;
    logic level;
    modport ctl (output ratio, output tick_in, input tick_out, input level);
    modport div (input ratio, input tick_in, output tick_out, output level);
endinterface
`default_nettype wire

// File: rtl/csd_divider.sv
`timescale 1ns/100ps
`default_nettype none
module csd_divider #(parameter int W = 4) (
    input wire logic clk,
    input wire logic rst,
    csd_div_if.div d
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // ratio holds divide value minus one; a shrunk ratio wraps at once
    always_comb begin
        if (cnt >= d.ratio) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
        end else if (d.tick_in) begin
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            d.tick_out <= 1'b0;
        end else begin
            d.tick_out <= d.tick_in && (cnt >= d.ratio);
        end
    end

    // high for the first half of the period; divide by one stays high
    always_ff @(posedge clk) begin
        if (rst) begin
            d.level <= 1'b0;
        end else if (d.tick_in) begin
            d.level <= next_cnt <= {1'b0, d.ratio[W-1:1]};
        end
    end
endmodule
`default_nettype wire

// File: rtl/csd_pkg.sv
package csd_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_PLL_CONTROL_ONE = 32'hFFFFFF70;
    localparam logic [31:0] ADDR_PLL_CONTROL_TWO = 32'hFFFFFF74;
    localparam logic [31:0] ADDR_PLL_CONTROL_THREE = 32'hFFFFFF78;
    localparam logic [31:0] ADDR_DIE_IDENTITY_LOW = 32'hFFFFFF7C;
    localparam logic [31:0] ADDR_DIE_IDENTITY_HIGH = 32'hFFFFFF80;
    localparam logic [31:0] ADDR_DEVICE_IDENTITY = 32'hFFFFFF84;
    localparam logic [31:0] ADDR_EXT_CLOCK_PRESCALE_CTL = 32'hFFFFFF88;
    localparam logic [31:0] ADDR_CLOCK_DIVIDER_CTL = 32'hFFFFFF8C;
    localparam logic [31:0] ADDR_SUPERVISOR_STATE = 32'hFFFFFF90;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFFFFFF94;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFFFF98;

    // reset values
    localparam logic [31:0] RST_PLL_CONTROL_ONE = 32'h2F025F00;
    localparam logic [31:0] RST_PLL_CONTROL_TWO = 32'h7FC07200;
    localparam logic [31:0] RST_PLL_CONTROL_THREE = 32'h00000307;
    localparam logic [31:0] RST_ZERO = 32'h00000000;

    // field layout
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_W = 16;
    localparam int BUS_DIV_LSB = 16;
    localparam int BUS_DIV_W = 4;
    localparam int SUP_FAIL_BIT = 0;
    localparam int SUP_LIMP_BIT = 1;
    localparam int EVT_OSC_FAIL_BIT = 0;
    localparam int EVT_W = 1;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // oscillator window: rising edges counted per measuring window
    localparam int WIN_W = 8;
    localparam logic [WIN_W-1:0] WIN_LAST = 8'hFF;
    localparam logic [WIN_W-1:0] OSC_EDGES_MIN = 8'h10;
    localparam logic [WIN_W-1:0] OSC_EDGES_MAX = 8'h70;
    localparam logic [WIN_W-1:0] EDGE_SAT = 8'hFF;

    // dead time with both clock enables low during switchover
    localparam int GAP_W = 3;
    localparam logic [GAP_W-1:0] GAP_LAST = 3'h3;

    typedef enum logic [2:0] {
        CSD_SUP_OSC = 3'b001,
        CSD_SUP_GAP = 3'b010,
        CSD_SUP_LIMP = 3'b100
    } csd_sup_state_t;
endpackage

// File: testbench/csd_clock_supervision_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module csd_clock_supervision_tb_top;
    localparam logic [31:0] DIE_LO = 32'h1234ABCD; // arbitrary
    localparam logic [31:0] DIE_HI = 32'h0BAD0F0E; // arbitrary
    localparam logic [31:0] DEV_ID = 32'h5A5A0001; // arbitrary
    localparam logic [31:0] PLL_A [3] = '{32'hFFFFFF70, 32'hFFFFFF74, 32'hFFFFFF78};
    localparam logic [31:0] RO_A [5] = '{32'hFFFFFF7C, 32'hFFFFFF80, 32'hFFFFFF84, 32'hFFFFFF90, 32'hFFFFFF9C};
    localparam int XS [3] = '{2, 5, 16};
    logic clk = 1'b0;
    logic rst, por_rst, oscillator_input_pin, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [31:0] pll_control_one, pll_control_two, pll_control_three;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic osc_clock_enable, lpo_clock_enable, osc_failure_flag, peripheral_bus_clock_en, external_clock_output;
    logic [15:0] osc_half;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] exp_reg [logic [31:0]];

    csd_clock_supervision #(.DIE_ID_LOW(DIE_LO), .DIE_ID_HIGH(DIE_HI), .DEVICE_IDENTITY(DEV_ID)) u_dut (
        .clk, .rst, .por_rst, .oscillator_input_pin, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_clock_enable, .lpo_clock_enable, .osc_failure_flag,
        .peripheral_bus_clock_en, .external_clock_output, .pll_control_one, .pll_control_two,
        .pll_control_three, .irq
    );
    csd_osc_model u_osc (.half_ns(osc_half), .osc_out(oscillator_input_pin));

    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // status is only modelled across power-on reset; warm reset state of it is left open
    function automatic void model_reset(input logic por);
        exp_reg[PLL_A[0]] = csd_pkg::RST_PLL_CONTROL_ONE;
        exp_reg[PLL_A[1]] = csd_pkg::RST_PLL_CONTROL_TWO;
        exp_reg[PLL_A[2]] = csd_pkg::RST_PLL_CONTROL_THREE;
        exp_reg[RO_A[0]] = DIE_LO;
        exp_reg[RO_A[1]] = DIE_HI;
        exp_reg[RO_A[2]] = DEV_ID;
        exp_reg[csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL] = 32'h00000000;
        exp_reg[csd_pkg::ADDR_CLOCK_DIVIDER_CTL] = 32'h00000000;
        exp_reg[csd_pkg::ADDR_IRQ_MASK] = 32'h00000000;
        if (por) begin
            exp_reg[RO_A[3]] = 32'h00000000;
            exp_reg[csd_pkg::ADDR_IRQ_STATUS] = 32'h00000000;
        end
    endfunction

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ka, kw, kb;
        @(posedge clk);
        {ka, kw, kb} = 3'b111;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (kb) begin
            @(posedge clk);
            if (ka && s_axi_awready) begin
                ka = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (kw && s_axi_wready) begin
                kw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                kb = 1'b0;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ka, kr;
        @(posedge clk);
        {ka, kr} = 2'b11;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (kr) begin
            @(posedge clk);
            if (ka && s_axi_arready) begin
                ka = 1'b0;
                s_axi_arvalid <= 1'b0;
            end else if (!ka && s_axi_rvalid) begin
                kr = 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check(r, exp_reg.exists(a) ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR);
        if (exp_reg.exists(a) && !(a inside {RO_A[0], RO_A[1], RO_A[2], RO_A[3]})) exp_reg[a] = d;
    endtask

    task automatic reg_rd(input logic [31:0] a);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(r, exp_reg.exists(a) ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR);
        if (exp_reg.exists(a)) check(d, exp_reg[a]);
        if (a == csd_pkg::ADDR_IRQ_STATUS) exp_reg[a] = 32'h00000000;
    endtask

    task automatic measure(input logic sel, output int per, output int hi);
        logic prev, cur;
        {per, hi, prev, cur} = '1;
        while (!(cur && !prev)) begin
            @(negedge clk);
            prev = cur;
            cur = sel ? external_clock_output : peripheral_bus_clock_en;
        end
        {per, hi} = '0;
        do begin
            hi += int'(cur);
            per++;
            @(negedge clk);
            prev = cur;
            cur = sel ? external_clock_output : peripheral_bus_clock_en;
        end while (!(cur && !prev));
    endtask

    always @(negedge clk) if (!rst && !por_rst) check(32'(osc_clock_enable & lpo_clock_enable), 0);

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial begin
        int per, hi, nv, n;
        {rst, por_rst} = 2'b11;
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        osc_half = 16'h0067;
        void'($urandom(32'h6C519033));
        model_reset(1'b1);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        por_rst <= 1'b0;
        @(negedge clk);
        check(pll_control_one, csd_pkg::RST_PLL_CONTROL_ONE);
        check(pll_control_two, csd_pkg::RST_PLL_CONTROL_TWO);
        check(pll_control_three, csd_pkg::RST_PLL_CONTROL_THREE);
        foreach (PLL_A[i]) reg_rd(PLL_A[i]);
        foreach (RO_A[i]) reg_wr(RO_A[i], $urandom);
        foreach (RO_A[i]) reg_rd(RO_A[i]);
        foreach (PLL_A[i]) reg_wr(PLL_A[i], $urandom);
        foreach (PLL_A[i]) reg_rd(PLL_A[i]);
        @(negedge clk);
        check(pll_control_one, exp_reg[PLL_A[0]]);
        check(pll_control_two, exp_reg[PLL_A[1]]);
        check(pll_control_three, exp_reg[PLL_A[2]]);
        foreach (XS[i]) begin
            // divide by two once so the toggle check sees traffic
            nv = (i == 0) ? 2 : $urandom_range(40, 2);
            reg_wr(csd_pkg::ADDR_CLOCK_DIVIDER_CTL, 32'(XS[i] - 1) << csd_pkg::BUS_DIV_LSB);
            reg_wr(csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL, 32'(nv - 1));
            repeat (2) measure(1'b0, per, hi);
            check(per, XS[i]);
            check(hi, 1);
            repeat (2) measure(1'b1, per, hi);
            check(per, XS[i] * nv);
            check(hi, XS[i] * ((nv - 1) / 2 + 1));
        end
        reg_wr(csd_pkg::ADDR_EXT_CLOCK_PRESCALE_CTL, 32'h00000000);
        repeat (100) @(negedge clk);
        check(external_clock_output, 1);
        // masked first, so the event must not reach the interrupt line yet
        osc_half <= 16'h0000;
        n = 0;
        while (osc_failure_flag !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(osc_failure_flag, 1);
        check(osc_clock_enable, 0);
        repeat (6) @(negedge clk);
        check(lpo_clock_enable, 1);
        check(irq, 0);
        exp_reg[RO_A[3]] = 32'h00000003;
        exp_reg[csd_pkg::ADDR_IRQ_STATUS] = 32'h00000001;
        reg_rd(RO_A[3]);
        reg_wr(csd_pkg::ADDR_IRQ_MASK, 32'h00000001);
        @(negedge clk);
        check(irq, 1);
        reg_rd(csd_pkg::ADDR_IRQ_STATUS);
        @(negedge clk);
        check(irq, 0);
        reg_rd(csd_pkg::ADDR_IRQ_STATUS);
        osc_half <= 16'h0067;
        repeat (800) @(posedge clk);
        reg_rd(RO_A[3]);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        model_reset(1'b0);
        @(negedge clk);
        check({osc_failure_flag, lpo_clock_enable, osc_clock_enable}, 3'b110);
        reg_rd(RO_A[3]);
        por_rst <= 1'b1;
        repeat (2) @(posedge clk);
        por_rst <= 1'b0;
        model_reset(1'b1);
        @(negedge clk);
        check({osc_failure_flag, lpo_clock_enable, osc_clock_enable}, 3'b001);
        reg_rd(RO_A[3]);
        test_done();
    end
endmodule
`default_nettype wire

// File: testbench/csd_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module csd_osc_model (
    input wire logic [15:0] half_ns,
    output logic osc_out
);
    // own time base, no phase relation to the system clock
    initial osc_out = 1'b0;
    always begin
        if (half_ns == 16'h0000) begin
            #50;
        end else begin
            #(half_ns);
            osc_out = ~osc_out;
        end
    end
endmodule
`default_nettype wire
